// file: hw/digipot_pkg.sv
// Shared constants for the digital potentiometer serial port and its host.
package digipot_pkg;
	localparam logic [7:0] ID_BYTE        = 8'h50;
	localparam logic [3:0] OP_READ        = 4'hB;
	localparam logic [3:0] OP_WRITE       = 4'hC;
	localparam logic [3:0] ADDR_WIPER0    = 4'h0;
	localparam logic [3:0] ADDR_WIPER1    = 4'h1;
	localparam logic [3:0] ADDR_LAST_GP   = 4'h6;
	localparam logic [3:0] ADDR_ACR       = 4'h8;
	localparam int         ACR_VOL_BIT    = 7;
	localparam int         ACR_SHUTDOWN_N_PIN_BIT   = 6;
	localparam int         ACR_WIP_BIT    = 5;
	localparam logic [7:0] ACR_RESET      = 8'h40;
	localparam logic [6:0] WIPER_RESET    = 7'h40;
	localparam logic [6:0] WIPER_MIN      = 7'h00;
	localparam logic [6:0] WIPER_MAX      = 7'h7F;
	localparam logic [7:0] NV_RESET       = 8'h40;
	localparam int         CLK_PERIOD_NS  = 8;
	localparam int         NV_WRITE_MS    = 20;
	localparam int         NV_WRITE_CYCLES = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
	// Each clock half lasts SCK_DIV + 1 cycles, keeping the link under 5 MHz.
	localparam int         SCK_DIV        = 12;
	localparam int         CS_DESEL_NS    = 2000;
	localparam int         CS_DESEL_CYCLES =
		(CS_DESEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         LEAD_NS        = 250;
	localparam int         LEAD_CYCLES    =
		(LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] BIT_LAST       = 3'h7;
	localparam logic [1:0] BYTE_DATA      = 2'h2;
endpackage : digipot_pkg

// file: hw/spi_digipot_host.sv
// Host end: serial master with an Avalon-MM command register set.
`timescale 1ns/100ps
module spi_digipot_host
	import digipot_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic [3:0] address,
	input  wire logic       read,
	input  wire logic       write,
	input  wire logic [31:0] writedata,
	output logic [31:0]     readdata,
	output logic            waitrequest,
	spi_link_if.host        link
);
	typedef enum logic [2:0] {
		H_IDLE, H_LEAD, H_LOW, H_HIGH, H_GAP, H_DESEL
	} hstate_e;

	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CTRL   = 4'h8;

	hstate_e     state;
	logic [1:0]  sdo_sync;
	logic [23:0] tx;
	logic [7:0]  rx;
	logic [4:0]  bits;
	logic [7:0]  cnt;
	logic        busy;
	logic        ack;

	wire stall = write && address == REG_CMD && busy;
	wire take  = (read || write) && !ack && !stall;
	// A write acts only at the edge where the master sees waitrequest low.
	wire start = write && address == REG_CMD && ack;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sdo_sync <= 2'h3;
		else
			sdo_sync <= {sdo_sync[0], link.sdo};
	end

	// Host keeps the shutdown pin high unless software asks otherwise.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			link.shutdown_n_pin <= 1'b1;
		else if (write && ack && address == REG_CTRL)
			link.shutdown_n_pin <= writedata[0];
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack         <= 1'b0;
			waitrequest <= 1'b1;
			readdata    <= 32'h0;
		end else begin
			ack         <= take;
			waitrequest <= !take;
			if (read && !ack)
				readdata <= (address == REG_STATUS)
					? {23'h0, busy, rx} : {31'h0, link.shutdown_n_pin};
		end
	end

	// Frame: ID byte, opcode and address, one data byte, MSB first, mode 0.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state     <= H_IDLE;
			link.cs_n <= 1'b1;
			link.sck  <= 1'b0;
			link.sdi  <= 1'b0;
			tx        <= 24'h0;
			rx        <= 8'h00;
			bits      <= 5'h0;
			cnt       <= 8'h00;
			busy      <= 1'b0;
		end else begin
			case (state)
			H_IDLE: begin
				if (start) begin
					tx        <= {ID_BYTE, writedata[11:8],
						writedata[3:0], writedata[23:16]};
					busy      <= 1'b1;
					link.cs_n <= 1'b0;
					cnt       <= 8'(LEAD_CYCLES);
					bits      <= 5'h0;
					state     <= H_LEAD;
				end
			end
			H_LEAD: begin
				link.sdi <= tx[23];
				cnt      <= cnt - 8'h1;
				if (cnt == 8'h0) begin
					cnt   <= 8'(SCK_DIV);
					state <= H_LOW;
				end
			end
			H_LOW: begin
				cnt <= cnt - 8'h1;
				if (cnt == 8'h0) begin
					link.sck <= 1'b1;
					rx       <= {rx[6:0], sdo_sync[1]};
					tx       <= {tx[22:0], 1'b0};
					cnt      <= 8'(SCK_DIV);
					state    <= H_HIGH;
				end
			end
			H_HIGH: begin
				cnt <= cnt - 8'h1;
				if (cnt == 8'h0) begin
					link.sck <= 1'b0;
					link.sdi <= tx[23];
					bits     <= bits + 5'h1;
					// The lag before select rises matches the lead time.
					if (bits == 5'h17) begin
						cnt   <= 8'(LEAD_CYCLES);
						state <= H_GAP;
					end else begin
						cnt   <= 8'(SCK_DIV);
						state <= H_LOW;
					end
				end
			end
			H_GAP: begin
				cnt <= cnt - 8'h1;
				if (cnt == 8'h0) begin
					link.cs_n <= 1'b1;
					cnt       <= 8'(CS_DESEL_CYCLES);
					state     <= H_DESEL;
				end
			end
			// Staying busy through the deselect time stalls the next frame.
			H_DESEL: begin
				cnt <= cnt - 8'h1;
				if (cnt == 8'h0) begin
					busy  <= 1'b0;
					state <= H_IDLE;
				end
			end
			default: begin
				state <= H_IDLE;
			end
			endcase
		end
	end
endmodule : spi_digipot_host

// file: hw/spi_digipot_serial_port.sv
// Device end: serial slave, registers, shutdown and self-timed NV write.
//
// Summary of operation
// [R01] Shutdown opens arrays, grounds every wiper.
// [R02] Leaving shutdown restores retained wiper taps.
// [R03] Shutdown pin OR control bit shuts down.
// [R04] Serial port works fully during shutdown.
// [R05] Host holds shutdown pin high normally.
// [R06] Read bits shift out on clock fall.
// [R07] Data output only pulls low or releases.
// [R08] Host supplies pull-up on data output.
// [R09] Data input sampled on clock rise.
// [R10] Host sends ID, opcode, address, then data.
// [R11] Select low makes device active.
// [R12] No operation before first select fall.
// [R13] Deselected device releases data output.
// [R14] Standby deferred while NV write runs.
// [R15] Wiper tap follows its wiper register.
// [R16] Codes 00 to 7F span taps.
// [R17] NV write self-timed after sequence end.
// [R18] Mode zero, most significant bit first.
// [R19] Upper nibble opcode, lower nibble address.
// [R20] Control bit 6 zero means shutdown.
// [R21] NV write busy flag refuses writes.
// [R22] Select fall clears bit, byte counters.
`timescale 1ns/100ps
module spi_digipot_serial_port
	import digipot_pkg::*;
#(
	parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       resetn,
	spi_link_if.device      link,
	output logic [6:0]      wiper_terminal0,
	output logic [6:0]      wiper_terminal1,
	output logic            array_open,
	output logic            active_mode,
	output logic            standby,
	output logic            nv_write_in_progress_flag
);
	typedef enum logic [1:0] {ST_ID, ST_CMD, ST_DATA, ST_IGNORE} phase_e;

	logic [2:0]  cs_sync;
	logic [2:0]  sck_sync;
	logic [1:0]  sdi_sync;
	logic [1:0]  shutdown_n_pin_sync;
	logic [7:0]  initial_value_reg [0:ADDR_LAST_GP];
	logic [6:0]  wiper_position_reg [0:1];
	logic [7:0]  access_control_reg;
	logic        armed;
	logic [2:0]  bit_cnt;
	logic [7:0]  shift_in;
	logic [7:0]  shift_out;
	logic [3:0]  pointer;
	logic        is_read;
	logic        nv_pending;
	logic [31:0] nv_cnt;
	logic [3:0]  nv_addr;
	logic [7:0]  nv_data;
	logic        nv_start;
	phase_e      phase;

	wire cs_low   = !cs_sync[1];
	wire cs_fall  = cs_sync[2] && !cs_sync[1];
	wire cs_rise  = !cs_sync[2] && cs_sync[1];
	wire sck_rise = !sck_sync[2] && sck_sync[1];
	wire sck_fall = sck_sync[2] && !sck_sync[1];
	wire [7:0] byte_in = {shift_in[6:0], sdi_sync[1]};
	wire byte_done = cs_low && armed && sck_rise && bit_cnt == BIT_LAST;

	function automatic logic [3:0] next_addr(input logic [3:0] a);
		next_addr = (a >= ADDR_LAST_GP) ? ADDR_WIPER0 : a + 4'h1;
	endfunction : next_addr

	function automatic logic [7:0] reg_read(input logic [3:0] a);
		if (a == ADDR_ACR)
			reg_read = {access_control_reg[7:6], nv_pending, 5'h00};
		else if (a <= ADDR_WIPER1 && access_control_reg[ACR_VOL_BIT])
			reg_read = {1'b0, wiper_position_reg[a[0]]};
		else if (a <= ADDR_LAST_GP)
			reg_read = initial_value_reg[a[2:0]];
		else
			reg_read = 8'h00;
	endfunction : reg_read

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cs_sync   <= 3'h7;
			sck_sync  <= 3'h0;
			sdi_sync  <= 2'h0;
			shutdown_n_pin_sync <= 2'h3;
		end else begin
			cs_sync   <= {cs_sync[1:0], link.cs_n};
			sck_sync  <= {sck_sync[1:0], link.sck};
			sdi_sync  <= {sdi_sync[0], link.sdi};
			shutdown_n_pin_sync <= {shutdown_n_pin_sync[0], link.shutdown_n_pin};
		end
	end

	// [R12] first select fall
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			armed <= 1'b0;
		else if (cs_fall)
			armed <= 1'b1;
	end

	// [R09] [R18] [R22] rising sample
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt  <= 3'h0;
		end else if (cs_low && armed && sck_rise) begin
			bit_cnt  <= bit_cnt + 3'h1;
			shift_in <= byte_in;
		end
	end

	// [R10] [R19] [R22] byte sequencing
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			phase   <= ST_ID;
			pointer <= 4'h0;
			is_read <= 1'b0;
		end else if (cs_fall) begin
			phase   <= ST_ID;
			is_read <= 1'b0;
		end else if (byte_done) begin
			case (phase)
			ST_ID: begin
				phase <= (byte_in == ID_BYTE) ? ST_CMD : ST_IGNORE;
			end
			ST_CMD: begin
				pointer <= byte_in[3:0];
				is_read <= byte_in[7:4] == OP_READ;
				if (byte_in[7:4] == OP_READ || byte_in[7:4] == OP_WRITE)
					phase <= ST_DATA;
				else
					phase <= ST_IGNORE;
			end
			ST_DATA: begin
				pointer <= next_addr(pointer);
			end
			default: begin
				phase <= ST_IGNORE;
			end
			endcase
		end
	end

	// [R06] falling shift out
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			shift_out <= 8'hFF;
		else if (byte_done && phase == ST_CMD)
			shift_out <= reg_read(byte_in[3:0]);
		else if (byte_done && phase == ST_DATA)
			shift_out <= reg_read(next_addr(pointer));
		else if (cs_low && sck_fall && is_read && phase == ST_DATA)
			shift_out <= {shift_out[6:0], 1'b1};
	end

	// [R07] [R13] open drain
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			link.sdo_oe  <= 1'b0;
			link.sdo_out <= 1'b0;
		end else begin
			link.sdo_out <= 1'b0;
			// Bits move only on a clock fall, so the line is settled well before
			// the clock rise at which the host samples it.
			if (!(cs_low && is_read && phase == ST_DATA))
				link.sdo_oe <= 1'b0;
			else if (sck_fall)
				link.sdo_oe <= !shift_out[7];
		end
	end

	wire wr_ok = byte_done && phase == ST_DATA && !is_read && !nv_pending;
	wire nv_target = pointer <= ADDR_LAST_GP
		&& !(pointer <= ADDR_WIPER1 && access_control_reg[ACR_VOL_BIT]);

	// [R21] [R04] register writes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			access_control_reg <= ACR_RESET;
			wiper_position_reg[0] <= WIPER_RESET;
			wiper_position_reg[1] <= WIPER_RESET;
		end else if (wr_ok) begin
			if (pointer == ADDR_ACR)
				access_control_reg <= {byte_in[7:6], 6'h00};
			else if (pointer <= ADDR_WIPER1)
				wiper_position_reg[pointer[0]] <= byte_in[6:0];
		end
	end

	// Pending NV data is latched; one write per select frame.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			nv_start <= 1'b0;
			nv_addr  <= 4'h0;
			nv_data  <= 8'h00;
		end else if (cs_fall) begin
			nv_start <= 1'b0;
		end else if (wr_ok && nv_target && !nv_start) begin
			nv_start <= 1'b1;
			nv_addr  <= pointer;
			nv_data  <= byte_in;
		end else if (cs_rise) begin
			nv_start <= 1'b0;
		end
	end

	// [R17] [R21] self-timed cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			nv_pending <= 1'b0;
			nv_cnt     <= 32'h0;
		end else if (cs_rise && nv_start) begin
			nv_pending <= 1'b1;
			nv_cnt     <= 32'h0;
		end else if (nv_pending) begin
			nv_cnt <= nv_cnt + 32'h1;
			if (nv_cnt >= NV_CYCLES - 1)
				nv_pending <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i <= ADDR_LAST_GP; i++)
				initial_value_reg[i] <= NV_RESET;
		end else if (cs_rise && nv_start) begin
			initial_value_reg[nv_addr[2:0]] <= nv_data;
		end
	end

	wire shut = !shutdown_n_pin_sync[1] || !access_control_reg[ACR_SHUTDOWN_N_PIN_BIT];

	// [R01] [R02] [R03] [R15] [R16] [R20] wiper outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wiper_terminal0 <= WIPER_MIN;
			wiper_terminal1 <= WIPER_MIN;
			array_open      <= 1'b0;
		end else begin
			array_open      <= shut;
			wiper_terminal0 <= shut ? WIPER_MIN : wiper_position_reg[0];
			wiper_terminal1 <= shut ? WIPER_MIN : wiper_position_reg[1];
		end
	end

	// [R11] [R14] power modes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			active_mode <= 1'b0;
			standby     <= 1'b1;
			nv_write_in_progress_flag <= 1'b0;
		end else begin
			active_mode <= cs_low;
			standby     <= !cs_low && !nv_pending;
			nv_write_in_progress_flag <= nv_pending;
		end
	end
endmodule : spi_digipot_serial_port

// file: hw/spi_link_if.sv
// Serial link between host and potentiometer device.
`timescale 1ns/100ps
interface spi_link_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo_out;
	logic sdo_oe;
	logic sdo;
	logic shutdown_n_pin;
	// Open-drain data line with external pull-up: low only while driven.
	assign sdo = !(sdo_oe && !sdo_out);
	modport device (
		input  cs_n,
		input  sck,
		input  sdi,
		input  shutdown_n_pin,
		output sdo_out,
		output sdo_oe
	);
	modport host (
		output cs_n,
		output sck,
		output sdi,
		output shutdown_n_pin,
		input  sdo
	);
endinterface : spi_link_if

// file: verification/spi_digipot_serial_port_asserts.sv
// Checker for the serial link between host and potentiometer.
`timescale 1ns/100ps
module spi_link_asserts (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic sdo,
	input wire logic shutdown_n_pin
);
	logic [5:0] rises;
	logic       sck_q;
	logic [4:0] high_cnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Counting rises catches a frame that is cut short or runs long.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rises <= 6'h00;
			sck_q <= 1'b0;
		end else begin
			sck_q <= sck;
			rises <= cs_n ? 6'h00 : rises + {5'h00, sck & !sck_q};
		end
	end
	// A counter measures the clock's high time, too long to repeat.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			high_cnt <= 5'h00;
		else
			high_cnt <= sck ? high_cnt + 5'h01 : 5'h00;
	end
	oe_released_a: assert property (cs_n[*5] |-> !sdo_oe)
		else $error("Data output driven while deselected.");
	drain_only_a: assert property (sdo_oe |-> !sdo_out)
		else $error("Data output driven high.");
	line_pullup_a: assert property (!sdo_oe |-> sdo)
		else $error("Released data line not high.");
	shift_fall_a: assert property ($changed(sdo_oe) |-> !sck)
		else $error("Data output changed while clock high.");
	idle_low_a: assert property (cs_n |-> !sck)
		else $error("Serial clock high while deselected.");
	sdi_hold_a: assert property (sck |-> $stable(sdi))
		else $error("Data input moved while clock high.");
	sck_high_a: assert property ($fell(sck) |-> high_cnt == 5'h0D)
		else $error("Serial clock high time wrong.");
	select_lead_a: assert property ($fell(cs_n) |-> !sck[*8])
		else $error("Clock rose too soon after select.");
	frame_len_a: assert property ($rose(cs_n) |-> rises == 6'h18)
		else $error("Frame did not carry 24 bits.");
	cover property ($rose(sdo_oe));
	cover property ($rose(cs_n));
	cover property ($fell(shutdown_n_pin));
endmodule : spi_link_asserts

// file: verification/spi_digipot_serial_port_tb.sv
// Self-checking bench joining the host and the potentiometer device.
`timescale 1ns/100ps
module spi_digipot_serial_port_tb
	import digipot_pkg::*;
;
	logic        mclk;
	logic        resetn;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [6:0]  wiper0;
	logic [6:0]  wiper1;
	logic        array_open;
	logic        active_mode;
	logic        standby;
	logic        nv_flag;
	logic [31:0] rd;
	int          tries;
	int          mismatches;
	int          check_count;
	spi_link_if link ();
	// A shorter NV cycle keeps the run brief yet outlasts two frames.
	spi_digipot_serial_port #(.NV_CYCLES(4000)) spi_digipot_serial_port_inst (
		.mclk                      (mclk),
		.resetn                    (resetn),
		.link                      (link),
		.wiper_terminal0           (wiper0),
		.wiper_terminal1           (wiper1),
		.array_open                (array_open),
		.active_mode               (active_mode),
		.standby                   (standby),
		.nv_write_in_progress_flag (nv_flag)
	);
	spi_digipot_host spi_digipot_host_inst (
		.mclk        (mclk),
		.resetn      (resetn),
		.address     (address),
		.read        (read),
		.write       (write),
		.writedata   (writedata),
		.readdata    (readdata),
		.waitrequest (waitrequest),
		.link        (link)
	);
	spi_link_asserts spi_link_asserts_inst (
		.mclk           (mclk),
		.resetn         (resetn),
		.cs_n           (link.cs_n),
		.sck            (link.sck),
		.sdi            (link.sdi),
		.sdo_out        (link.sdo_out),
		.sdo_oe         (link.sdo_oe),
		.sdo            (link.sdo),
		.shutdown_n_pin (link.shutdown_n_pin)
	);
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 200);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			mismatches++;
			stop_test();
		end
	endtask : av
	task automatic xfer(input logic [3:0] op, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		av(1'b1, 4'h0, {8'h00, d, 4'h0, op, 4'h0, a});
		repeat (40) @(posedge mclk);
		chk("active", 8'h01, {7'h00, active_mode});
		chk("standby", 8'h00, {7'h00, standby});
		n = 0;
		do begin
			av(1'b0, 4'h4, 32'h0);
			n++;
		end while (rd[8] !== 1'b0 && n < 500);
		if (rd[8] !== 1'b0) begin
			mismatches++;
			stop_test();
		end
		repeat (8) @(posedge mclk);
	endtask : xfer
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		resetn = 1'b0;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		mismatches = 0;
		check_count = 0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		av(1'b1, 4'h8, 32'h1);
		xfer(OP_READ, ADDR_ACR, 8'h00);
		chk("acr", ACR_RESET, rd[7:0]);
		chk("wiper0", {1'b0, WIPER_RESET}, {1'b0, wiper0});
		xfer(OP_WRITE, ADDR_ACR, 8'hC0);
		xfer(OP_WRITE, ADDR_WIPER0, {1'b0, WIPER_MAX});
		chk("wiper0", {1'b0, WIPER_MAX}, {1'b0, wiper0});
		xfer(OP_WRITE, ADDR_WIPER1, {1'b0, WIPER_MIN});
		chk("wiper1", {1'b0, WIPER_MIN}, {1'b0, wiper1});
		xfer(OP_READ, ADDR_WIPER0, 8'h00);
		chk("read0", {1'b0, WIPER_MAX}, rd[7:0]);
		av(1'b1, 4'h8, 32'h0);
		repeat (8) @(posedge mclk);
		chk("open", 8'h01, {7'h00, array_open});
		chk("wiper0", 8'h00, {1'b0, wiper0});
		xfer(OP_WRITE, ADDR_WIPER1, 8'h55);
		xfer(OP_READ, ADDR_WIPER1, 8'h00);
		chk("read1", 8'h55, rd[7:0]);
		chk("wiper1", 8'h00, {1'b0, wiper1});
		av(1'b1, 4'h8, 32'h1);
		repeat (8) @(posedge mclk);
		chk("open", 8'h00, {7'h00, array_open});
		chk("wiper0", {1'b0, WIPER_MAX}, {1'b0, wiper0});
		chk("wiper1", 8'h55, {1'b0, wiper1});
		xfer(OP_WRITE, ADDR_ACR, 8'h80);
		chk("open", 8'h01, {7'h00, array_open});
		xfer(OP_WRITE, ADDR_ACR, 8'hC0);
		chk("open", 8'h00, {7'h00, array_open});
		xfer(OP_WRITE, ADDR_ACR, 8'h40);
		xfer(OP_WRITE, ADDR_WIPER0, 8'h12);
		chk("nv_flag", 8'h01, {7'h00, nv_flag});
		chk("standby", 8'h00, {7'h00, standby});
		xfer(OP_READ, ADDR_ACR, 8'h00);
		chk("acr", 8'h60, rd[7:0]);
		xfer(OP_WRITE, ADDR_WIPER1, 8'h33);
		tries = 0;
		while (nv_flag !== 1'b0 && tries < 3000) begin
			@(posedge mclk);
			tries++;
		end
		chk("nv_flag", 8'h00, {7'h00, nv_flag});
		chk("standby", 8'h01, {7'h00, standby});
		chk("wiper0", 8'h12, {1'b0, wiper0});
		chk("wiper1", 8'h55, {1'b0, wiper1});
		chk("active", 8'h00, {7'h00, active_mode});
		xfer(OP_READ, ADDR_WIPER0, 8'h00);
		chk("ivr0", 8'h12, rd[7:0]);
		stop_test();
	end
endmodule : spi_digipot_serial_port_tb
